// ===== include/pdsc_params.svh
// Constants of the input process-data and sync configuration bank.
// Assumes nothing; included by the design modules only, not by the package.
`ifndef PDSC_PARAMS_SVH
`define PDSC_PARAMS_SVH

// Object indices
`define IDX_SAMPLE49    16'h1a71
`define IDX_SAMPLE50    16'h1a72
`define IDX_TIMESTAMP   16'h1a80
`define IDX_CYCLE_CNT   16'h1a81
`define IDX_SM_TYPES    16'h1c00
`define IDX_OUT_ASSIGN  16'h1c12
`define IDX_IN_ASSIGN   16'h1c13
`define IDX_IN_SYNC     16'h1c33

// Sync parameter subentries
`define SUB_COUNT       8'h00
`define SUB_SYNC_MODE   8'h01
`define SUB_CYCLE_TIME  8'h02
`define SUB_SHIFT_TIME  8'h03
`define SUB_MODES_SUPP  8'h04

// Reset values
`define RST_MAP_COUNT   8'h01
`define RST_SM_COUNT    8'h04
`define RST_OUT_COUNT   8'h00
`define RST_IN_COUNT    8'h02
`define RST_SYNC_COUNT  8'h20
`define RST_SYNC_MODE   16'h0022
`define RST_CYCLE_TIME  32'h000f4240
`define RST_SHIFT_TIME  32'h00000000
`define RST_MODES_SUPP  16'hc007
`define RST_SLOT1       16'h1a80
`define RST_SLOT2       16'h1a81
`define RST_SLOT_OTHER  16'h0000

// Mapping entries: object, subentry, bit length
`define MAP_SAMPLE49    32'h60113110
`define MAP_SAMPLE50    32'h60113210
`define MAP_TIMESTAMP   32'h60200140
`define MAP_CYCLE_CNT   32'h60210110

// Sync manager channel roles
`define SM_MBX_WRITE    8'h01
`define SM_MBX_READ     8'h02
`define SM_PD_OUTPUT    8'h03
`define SM_PD_INPUT     8'h04

// Sync mode codes
`define MODE_FREE_RUN   16'h0000
`define MODE_SM3        16'h0001
`define MODE_DC_SYNC0   16'h0002
`define MODE_DC_SYNC1   16'h0003
`define MODE_SM2        16'h0022

// Assignment list size
`define SLOT_COUNT      104
`define SLOT_MAX        8'h68

`endif

// ===== include/pdsc_pkg.sv
// Types shared by the configuration bank modules.
// Assumes nothing; uses none of the params header.
package pdsc_pkg;
  typedef enum logic [1:0] {
    ERR_NONE, ERR_NO_OBJECT, ERR_READ_ONLY, ERR_BAD_VALUE
  } err_t;

  typedef enum logic [1:0] {PD_IDLE, PD_FETCH, PD_EMIT} pd_state_t;

  typedef logic [15:0] slot_t;
endpackage : pdsc_pkg

// ===== hdl/ro_object_table.sv
// Constant table of the read-only objects and subentries.
// Assumes the caller only reads it; it holds no state.
`timescale 1ns/1ps
`include "pdsc_params.svh"
module ro_object_table
  import pdsc_pkg::*;
(
  input  wire logic [15:0] index_i,
  input  wire logic [7:0]  sub_i,
  output logic             hit_o,
  output logic [31:0]      data_o
);
  // Lookup of fixed mapping, channel role and sync capability values
  always_comb begin
    hit_o  = 1'b1;
    data_o = 32'h0000_0000;
    case ({index_i, sub_i})
      {`IDX_SAMPLE49, 8'h00}:   data_o = {24'h0, `RST_MAP_COUNT};
      {`IDX_SAMPLE49, 8'h01}:   data_o = `MAP_SAMPLE49; // RULE12
      {`IDX_SAMPLE50, 8'h00}:   data_o = {24'h0, `RST_MAP_COUNT};
      {`IDX_SAMPLE50, 8'h01}:   data_o = `MAP_SAMPLE50; // RULE12
      {`IDX_TIMESTAMP, 8'h00}:  data_o = {24'h0, `RST_MAP_COUNT};
      {`IDX_TIMESTAMP, 8'h01}:  data_o = `MAP_TIMESTAMP; // RULE10
      {`IDX_CYCLE_CNT, 8'h00}:  data_o = {24'h0, `RST_MAP_COUNT};
      {`IDX_CYCLE_CNT, 8'h01}:  data_o = `MAP_CYCLE_CNT; // RULE11
      {`IDX_SM_TYPES, 8'h00}:   data_o = {24'h0, `RST_SM_COUNT}; // RULE3
      {`IDX_SM_TYPES, 8'h01}:   data_o = {24'h0, `SM_MBX_WRITE}; // RULE2
      {`IDX_SM_TYPES, 8'h02}:   data_o = {24'h0, `SM_MBX_READ}; // RULE2
      {`IDX_SM_TYPES, 8'h03}:   data_o = {24'h0, `SM_PD_OUTPUT}; // RULE3
      {`IDX_SM_TYPES, 8'h04}:   data_o = {24'h0, `SM_PD_INPUT}; // RULE3
      {`IDX_IN_SYNC, `SUB_COUNT}:
        data_o = {24'h0, `RST_SYNC_COUNT};
      {`IDX_IN_SYNC, `SUB_SHIFT_TIME}:
        data_o = `RST_SHIFT_TIME; // RULE7
      // Bit 0 free run, bit 1 SM2 sync, bits 3:2 = 01 DC
      {`IDX_IN_SYNC, `SUB_MODES_SUPP}:
        data_o = {16'h0, `RST_MODES_SUPP}; // RULE8 RULE9 RULE14
      default:                  hit_o = 1'b0;
    endcase
  end
endmodule : ro_object_table

// ===== hdl/assign_slot_store.sv
// Storage of the 104 input assignment slots, one write port and
// two combinational read ports. Assumes one write per clock.
`timescale 1ns/1ps
`include "pdsc_params.svh"
module assign_slot_store
  import pdsc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       we_i,
  input  wire logic [6:0] waddr_i,
  input  wire slot_t      wdata_i,
  input  wire logic [6:0] raddr_a_i,
  input  wire logic [6:0] raddr_b_i,
  output slot_t           rdata_a_o,
  output slot_t           rdata_b_o
);
  typedef struct packed {
    slot_t [`SLOT_COUNT-1:0] slot;
  } store_t;

  store_t s_r;
  store_t s_nxt;

  // Write decode; an out-of-range address changes nothing
  always_comb begin
    s_nxt = s_r;
    for (int i = 0; i < `SLOT_COUNT; i++) begin
      if (we_i && waddr_i == 7'(i)) begin
        s_nxt.slot[i] = wdata_i; // RULE5
      end
    end
  end

  // First two slots come up pointing at timestamp and counter
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_r         <= '0; // RULE4
      s_r.slot[0] <= `RST_SLOT1; // RULE4
      s_r.slot[1] <= `RST_SLOT2; // RULE4
    end else begin
      s_r <= s_nxt;
    end
  end

  // Reads beyond the last slot return zero
  assign rdata_a_o = (raddr_a_i < 7'(`SLOT_COUNT)) ?
                     s_r.slot[raddr_a_i] : 16'h0000;
  assign rdata_b_o = (raddr_b_i < 7'(`SLOT_COUNT)) ?
                     s_r.slot[raddr_b_i] : 16'h0000;
endmodule : assign_slot_store

// ===== hdl/process_data_sync_config.sv
// Input process-data and sync configuration object bank, with the
// walker that streams the assigned input objects each cycle.
// Assumes the mailbox front end presents one object access at a time,
// synchronous to clk_i, and the sample sources hold their values.
//
// Contract
// RULE1 - Sync mode 16 bit RW, default 34
// RULE2 - Channels 1, 2 report mailbox types 1, 2
// RULE3 - Channels 3, 4 process data; four channels
// RULE4 - Input list defaults: timestamp, counter, zeros
// RULE5 - 104 RW 16-bit input assignment slots
// RULE6 - Output assignment count RW, default zero
// RULE7 - Shift time RO 32 bit, zero
// RULE8 - Supported modes 0xC007; bit0 free run
// RULE9 - Bit 1: SM2 event sync supported
// RULE10 - Timestamp map: one 64-bit entry
// RULE11 - Counter map: one 16-bit entry
// RULE12 - Sample 49/50 maps: one 16-bit entry
// RULE13 - Cycle time RW 32 bit, 1000000 default
// RULE14 - Modes bits 3:2 = 01: DC supported
// RULE15 - Writes to read-only entries are refused
`timescale 1ns/1ps
`include "pdsc_params.svh"
module process_data_sync_config
  import pdsc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Object access port
  input  wire logic        req_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] index_i,
  input  wire logic [7:0]  subindex_i,
  input  wire logic [31:0] wdata_i,
  output logic             ack_o,
  output logic [31:0]      rdata_o,
  output err_t             err_o,
  // Live input values
  input  wire logic [63:0] next_sync_timestamp_i,
  input  wire logic [15:0] cycle_counter_value_i,
  input  wire logic [15:0] sample49_i,
  input  wire logic [15:0] sample50_i,
  // Cyclic input image stream
  input  wire logic        pd_start_i,
  output logic             pd_valid_o,
  output logic [15:0]      pd_data_o,
  output logic             pd_last_o,
  output logic             pd_done_o,
  output logic             pd_busy_o,
  // Configuration seen by the sampling logic
  output logic [15:0]      sync_mode_o,
  output logic [31:0]      cycle_time_o,
  output logic             dc_active_o
);

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    err_t        err;
    logic [15:0] sync_mode;
    logic [31:0] cycle_time;
    logic [7:0]  out_cnt;
    logic [7:0]  in_cnt;
    logic        dc_active;
    pd_state_t   pd_state;
    logic [6:0]  slot_idx;
    logic [1:0]  word_idx;
    logic [1:0]  word_last;
    logic [63:0] hold;
    logic        pd_valid;
    logic [15:0] pd_data;
    logic        pd_last;
    logic        pd_done;
    logic        pd_busy;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // Slot store and constant table
  logic        slot_we;
  logic [6:0]  slot_waddr;
  logic [6:0]  slot_raddr;
  slot_t       slot_rd_bus;
  slot_t       slot_rd_walk;
  logic        ro_hit;
  logic [31:0] ro_data;

  // Slot subentries 1..104 map to store addresses 0..103
  logic        is_slot;
  logic [7:0]  sub_m1;

  assign sub_m1     = subindex_i - 8'h01;
  assign is_slot    = (index_i == `IDX_IN_ASSIGN) &&
                      (subindex_i != 8'h00) &&
                      (subindex_i <= `SLOT_MAX);
  assign slot_raddr = sub_m1[6:0];
  assign slot_waddr = sub_m1[6:0];

  assign_slot_store u_slots (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .we_i      (slot_we),
    .waddr_i   (slot_waddr),
    .wdata_i   (wdata_i[15:0]),
    .raddr_a_i (slot_raddr),
    .raddr_b_i (s_r.slot_idx),
    .rdata_a_o (slot_rd_bus),
    .rdata_b_o (slot_rd_walk)
  );

  ro_object_table u_ro (
    .index_i (index_i),
    .sub_i   (subindex_i),
    .hit_o   (ro_hit),
    .data_o  (ro_data)
  );

  // A sync mode write is taken only for a documented code
  function automatic logic mode_ok(input logic [15:0] m);
    mode_ok = (m == `MODE_FREE_RUN) || (m == `MODE_SM3) ||
              (m == `MODE_DC_SYNC0) || (m == `MODE_DC_SYNC1) ||
              (m == `MODE_SM2);
  endfunction : mode_ok

  // Object access decode and cyclic walker
  always_comb begin
    s_nxt          = s_r;
    s_nxt.ack      = 1'b0;
    s_nxt.pd_valid = 1'b0;
    s_nxt.pd_last  = 1'b0;
    s_nxt.pd_done  = 1'b0;
    slot_we        = 1'b0;

    // Each request is answered one cycle later
    if (req_i) begin
      s_nxt.ack   = 1'b1;
      s_nxt.err   = ERR_NONE;
      s_nxt.rdata = 32'h0000_0000;
      if (ro_hit) begin
        if (wr_i) begin
          s_nxt.err = ERR_READ_ONLY; // RULE15
        end else begin
          s_nxt.rdata = ro_data;
        end
      end else if (is_slot) begin
        if (wr_i) begin
          slot_we = 1'b1; // RULE5
        end else begin
          s_nxt.rdata = {16'h0000, slot_rd_bus}; // RULE5
        end
      end else begin
        case ({index_i, subindex_i})
          {`IDX_OUT_ASSIGN, `SUB_COUNT}: begin
            // No output mapping exists, so only zero is legal
            if (!wr_i) begin
              s_nxt.rdata = {24'h0, s_r.out_cnt}; // RULE6
            end else if (wdata_i == 32'h0) begin
              s_nxt.out_cnt = wdata_i[7:0]; // RULE6
            end else begin
              s_nxt.err = ERR_BAD_VALUE;
            end
          end
          {`IDX_IN_ASSIGN, `SUB_COUNT}: begin
            if (!wr_i) begin
              s_nxt.rdata = {24'h0, s_r.in_cnt};
            end else if (wdata_i <= {24'h0, `SLOT_MAX}) begin
              s_nxt.in_cnt = wdata_i[7:0]; // RULE5
            end else begin
              s_nxt.err = ERR_BAD_VALUE;
            end
          end
          {`IDX_IN_SYNC, `SUB_SYNC_MODE}: begin
            if (!wr_i) begin
              s_nxt.rdata = {16'h0, s_r.sync_mode}; // RULE1
            end else if (wdata_i[31:16] == 16'h0 &&
                         mode_ok(wdata_i[15:0])) begin
              s_nxt.sync_mode = wdata_i[15:0]; // RULE1
            end else begin
              s_nxt.err = ERR_BAD_VALUE;
            end
          end
          {`IDX_IN_SYNC, `SUB_CYCLE_TIME}: begin
            if (wr_i) begin
              s_nxt.cycle_time = wdata_i; // RULE13
            end else begin
              s_nxt.rdata = s_r.cycle_time; // RULE13
            end
          end
          default: begin
            s_nxt.err = ERR_NO_OBJECT;
          end
        endcase
      end
    end

    // Shift time applies only while a DC mode is selected
    s_nxt.dc_active = (s_nxt.sync_mode == `MODE_DC_SYNC0) ||
                      (s_nxt.sync_mode == `MODE_DC_SYNC1); // RULE7

    // Walk the assigned slots and stream each object's words
    case (s_r.pd_state)
      PD_IDLE: begin
        // A start while busy is ignored; an empty list ends at once
        if (pd_start_i) begin
          s_nxt.slot_idx = 7'h00;
          if (s_r.in_cnt == 8'h00) begin
            s_nxt.pd_done = 1'b1;
          end else begin
            s_nxt.pd_state = PD_FETCH;
          end
        end
      end
      PD_FETCH: begin
        // Values are captured here so a multi-word item stays coherent
        s_nxt.word_idx = 2'd0;
        s_nxt.pd_state = PD_EMIT;
        case (slot_rd_walk)
          `IDX_TIMESTAMP: begin
            s_nxt.hold      = next_sync_timestamp_i; // RULE10
            s_nxt.word_last = 2'd3;
          end
          `IDX_CYCLE_CNT: begin
            s_nxt.hold      = {48'h0, cycle_counter_value_i}; // RULE11
            s_nxt.word_last = 2'd0;
          end
          `IDX_SAMPLE49: begin
            s_nxt.hold      = {48'h0, sample49_i}; // RULE12
            s_nxt.word_last = 2'd0;
          end
          `IDX_SAMPLE50: begin
            s_nxt.hold      = {48'h0, sample50_i}; // RULE12
            s_nxt.word_last = 2'd0;
          end
          default: begin
            // Unknown or empty slot contributes nothing
            s_nxt.pd_state = PD_FETCH;
            if ({1'b0, s_r.slot_idx} + 8'h01 >= s_r.in_cnt) begin
              s_nxt.pd_state = PD_IDLE;
              s_nxt.pd_done  = 1'b1;
            end else begin
              s_nxt.slot_idx = s_r.slot_idx + 7'h01;
            end
          end
        endcase
      end
      PD_EMIT: begin
        // Low word first
        s_nxt.pd_valid = 1'b1;
        s_nxt.pd_data  = s_r.hold[{s_r.word_idx, 4'h0} +: 16];
        if (s_r.word_idx == s_r.word_last) begin
          s_nxt.pd_last = 1'b1;
          if ({1'b0, s_r.slot_idx} + 8'h01 >= s_r.in_cnt) begin
            s_nxt.pd_state = PD_IDLE;
            s_nxt.pd_done  = 1'b1;
          end else begin
            s_nxt.slot_idx = s_r.slot_idx + 7'h01;
            s_nxt.pd_state = PD_FETCH;
          end
        end else begin
          s_nxt.word_idx = s_r.word_idx + 2'd1;
        end
      end
      default: begin
        s_nxt.pd_state = PD_IDLE;
      end
    endcase

    // Busy is kept in a flip-flop of its own so the port has no logic
    // behind the register; it follows the next walker state exactly
    s_nxt.pd_busy = (s_nxt.pd_state != PD_IDLE);
  end

  // State register; defaults match the delivered configuration
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_r            <= '0;
      s_r.err        <= ERR_NONE;
      s_r.sync_mode  <= `RST_SYNC_MODE; // RULE1
      s_r.cycle_time <= `RST_CYCLE_TIME; // RULE13
      s_r.out_cnt    <= `RST_OUT_COUNT; // RULE6
      s_r.in_cnt     <= `RST_IN_COUNT; // RULE4
      s_r.pd_state   <= PD_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign ack_o        = s_r.ack;
  assign rdata_o      = s_r.rdata;
  assign err_o        = s_r.err;
  assign pd_valid_o   = s_r.pd_valid;
  assign pd_data_o    = s_r.pd_data;
  assign pd_last_o    = s_r.pd_last;
  assign pd_done_o    = s_r.pd_done;
  assign pd_busy_o    = s_r.pd_busy;
  assign sync_mode_o  = s_r.sync_mode;
  assign cycle_time_o = s_r.cycle_time;
  assign dc_active_o  = s_r.dc_active;

endmodule : process_data_sync_config

// ===== sim/pdsc_chk.sv
// Assertions on the access port and stream of the config bank.
// Assumes a bind to process_data_sync_config; sees its ports only.
`timescale 1ns/1ps
module pdsc_chk
  import pdsc_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        req_i,
  input wire logic        wr_i,
  input wire logic [15:0] index_i,
  input wire logic [7:0]  subindex_i,
  input wire logic [31:0] wdata_i,
  input wire logic [31:0] rdata_o,
  input wire err_t        err_o,
  input wire logic        pd_valid_o,
  input wire logic        pd_last_o,
  input wire logic        pd_done_o,
  input wire logic [15:0] sync_mode_o,
  input wire logic [31:0] cycle_time_o,
  input wire logic        dc_active_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // Decode of the access in flight
  logic wq, rq, sy, wm, wc, ok, ro, ty, cn;
  assign wq = req_i && wr_i;
  assign rq = req_i && !wr_i;
  assign sy = index_i == 16'h1c33;
  assign wm = wq && sy && subindex_i == 8'h01;
  assign wc = wq && sy && subindex_i == 8'h02;
  assign ok = wdata_i inside {32'h0, 32'h1, 32'h2, 32'h3, 32'h22};
  assign ty = index_i == 16'h1c00 && subindex_i inside {[8'h01:8'h04]};
  assign cn = index_i == 16'h1c13 && subindex_i == 8'h00;
  // Mapping objects are read-only in both subentries
  assign ro = (sy && subindex_i inside {8'h00, 8'h03, 8'h04})
    || (index_i == 16'h1c00 && subindex_i <= 8'h04)
    || (index_i inside {16'h1a71, 16'h1a72, 16'h1a80, 16'h1a81}
        && subindex_i <= 8'h01);

  a_mode_taken: assert property (wm && ok |=>
    err_o == ERR_NONE && sync_mode_o == 16'($past(wdata_i)))
    else $error("sync mode write not applied");
  a_mode_refused: assert property (wm && !ok |=>
    err_o == ERR_BAD_VALUE && $stable(sync_mode_o))
    else $error("bad sync mode accepted");
  a_dc_flag: assert property (
    dc_active_o == (sync_mode_o inside {16'h2, 16'h3}))
    else $error("dc flag disagrees with mode");
  a_ro_refused: assert property (wq && ro |=>
    err_o == ERR_READ_ONLY && rdata_o == 32'h0)
    else $error("read-only write not refused");
  a_type_codes: assert property (rq && ty |=>
    rdata_o == 32'($past(subindex_i)))
    else $error("wrong channel type code");
  a_modes_mask: assert property (
    rq && sy && subindex_i == 8'h04 |=>
    rdata_o == 32'h0000c007 && err_o == ERR_NONE)
    else $error("wrong supported modes");
  a_shift_zero: assert property (rq && sy && subindex_i == 8'h03 |=>
    rdata_o == 32'h0 && err_o == ERR_NONE)
    else $error("shift time not zero");
  a_cycle_taken: assert property (wc |=>
    cycle_time_o == $past(wdata_i))
    else $error("cycle time write not applied");
  a_count_range: assert property (wq && cn && wdata_i > 32'h68 |=>
    err_o == ERR_BAD_VALUE)
    else $error("slot count above range accepted");
  a_last_word: assert property (pd_last_o |-> pd_valid_o)
    else $error("object end without a word");
  a_word_run: assert property (
    pd_valid_o && !pd_last_o |=> pd_valid_o)
    else $error("object words not back to back");

  c_walk_done: cover property (pd_done_o);
  c_mode_write: cover property (wm && ok);
  c_ro_write: cover property (wq && ro);
endmodule : pdsc_chk

bind process_data_sync_config pdsc_chk u_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .wr_i(wr_i),
  .index_i(index_i), .subindex_i(subindex_i), .wdata_i(wdata_i),
  .rdata_o(rdata_o), .err_o(err_o), .pd_valid_o(pd_valid_o),
  .pd_last_o(pd_last_o), .pd_done_o(pd_done_o),
  .sync_mode_o(sync_mode_o), .cycle_time_o(cycle_time_o),
  .dc_active_o(dc_active_o)
);

// ===== sim/pd_sink.sv
// Master-side sink of the cyclic input image stream.
// Assumes the stream port runs on the same clock as the bank.
`timescale 1ns/1ps
module pd_sink (
  input wire logic        clk_i,
  input wire logic        valid_i,
  input wire logic [15:0] data_i,
  input wire logic        last_i,
  input wire logic        done_i
);
  logic [16:0] words [$];
  int          dones = 0;

  // Keep each word with its object-end flag; never stalls the walker
  always @(posedge clk_i) begin
    if (valid_i) words.push_back({last_i, data_i});
    if (done_i) dones++;
  end
endmodule : pd_sink

// ===== sim/tb.sv
// Self-checking bench of the config bank and its input stream.
// Assumes the design files, pd_sink and the checker compile first.
`timescale 1ns/1ps
module tb;
  import pdsc_pkg::*;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        req_i = 1'b0;
  logic        wr_i = 1'b0;
  logic [15:0] index_i = 16'h0;
  logic [7:0]  subindex_i = 8'h0;
  logic [31:0] wdata_i = 32'h0;
  logic        pd_start_i = 1'b0;
  logic [63:0] ts = 64'h1111_2222_3333_4444;
  logic [15:0] cnt = 16'h0abc;
  logic [15:0] s49 = 16'h0049;
  logic [15:0] s50 = 16'h0050;
  logic        ack_o, pd_valid_o, pd_last_o, pd_done_o, pd_busy_o;
  logic        dc_active_o;
  logic [31:0] rdata_o, cycle_time_o;
  logic [15:0] pd_data_o, sync_mode_o;
  err_t        err_o;
  logic [16:0] exp_q [$];
  int          num_errors = 0;
  int          comparisons = 0;
  // Index, subentry and reset value of every entry but slots 4 to 103
  logic [55:0] dflt [24] = '{
    56'h1a71_00_00000001, 56'h1a71_01_60113110,
    56'h1a72_00_00000001, 56'h1a72_01_60113210,
    56'h1a80_00_00000001, 56'h1a80_01_60200140,
    56'h1a81_00_00000001, 56'h1a81_01_60210110,
    56'h1c00_00_00000004, 56'h1c00_01_00000001,
    56'h1c00_02_00000002, 56'h1c00_03_00000003,
    56'h1c00_04_00000004, 56'h1c12_00_00000000,
    56'h1c13_00_00000002, 56'h1c13_01_00001a80,
    56'h1c13_02_00001a81, 56'h1c13_03_00000000,
    56'h1c13_68_00000000, 56'h1c33_00_00000020,
    56'h1c33_01_00000022, 56'h1c33_02_000f4240,
    56'h1c33_03_00000000, 56'h1c33_04_0000c007};

  always #4 clk_i = ~clk_i;

  process_data_sync_config dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .wr_i(wr_i),
    .index_i(index_i), .subindex_i(subindex_i), .wdata_i(wdata_i),
    .ack_o(ack_o), .rdata_o(rdata_o), .err_o(err_o),
    .next_sync_timestamp_i(ts), .cycle_counter_value_i(cnt),
    .sample49_i(s49), .sample50_i(s50), .pd_start_i(pd_start_i),
    .pd_valid_o(pd_valid_o), .pd_data_o(pd_data_o),
    .pd_last_o(pd_last_o), .pd_done_o(pd_done_o),
    .pd_busy_o(pd_busy_o), .sync_mode_o(sync_mode_o),
    .cycle_time_o(cycle_time_o), .dc_active_o(dc_active_o));

  pd_sink sink (.clk_i(clk_i), .valid_i(pd_valid_o), .data_i(pd_data_o),
    .last_i(pd_last_o), .done_i(pd_done_o));

  task automatic end_of_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One access: request for one cycle, answer sampled a cycle later
  task automatic ax(input logic w, input logic [15:0] i,
      input logic [7:0] s, input logic [31:0] d, input logic [31:0] e,
      input err_t ee);
    @(negedge clk_i);
    req_i = 1'b1;
    wr_i = w;
    index_i = i;
    subindex_i = s;
    wdata_i = d;
    @(negedge clk_i);
    req_i = 1'b0;
    chk({31'h0, ack_o}, 32'h1);
    chk(rdata_o, e);
    chk(32'(err_o), 32'(ee));
  endtask : ax

  // Start one walk and compare the words the sink gathered
  task automatic walk;
    int k;
    sink.words.delete();
    sink.dones = 0;
    @(negedge clk_i);
    pd_start_i = 1'b1;
    @(negedge clk_i);
    pd_start_i = 1'b0;
    chk({31'h0, pd_busy_o}, {31'h0, exp_q.size() != 0});
    for (k = 0; k < 300 && sink.dones == 0; k++) @(negedge clk_i);
    if (sink.dones == 0) begin
      num_errors++;
      end_of_test();
    end else begin
      chk({31'h0, pd_busy_o}, 32'h0);
      chk(32'(sink.dones), 32'h1);
      chk(32'(sink.words.size()), 32'(exp_q.size()));
      foreach (exp_q[j])
        if (j < sink.words.size())
          chk(32'(sink.words[j]), 32'(exp_q[j]));
      exp_q.delete();
    end
  endtask : walk

  // Timestamp leaves as four words, low half first
  task automatic ts_words;
    exp_q.push_back({1'b0, ts[15:0]});
    exp_q.push_back({1'b0, ts[31:16]});
    exp_q.push_back({1'b0, ts[47:32]});
    exp_q.push_back({1'b1, ts[63:48]});
  endtask : ts_words

  task automatic t_defaults;
    chk(32'(sync_mode_o), 32'h22);
    chk(cycle_time_o, 32'h000f4240);
    // Every entry but slots 4 to 103 read back
    foreach (dflt[k])
      ax(1'b0, dflt[k][55:40], dflt[k][39:32], 32'h0, dflt[k][31:0],
        ERR_NONE);
  endtask : t_defaults

  // A refused write must leave the old value readable
  task automatic t_read_only;
    logic [31:0] v;
    logic [15:0] i;
    logic [7:0]  s;
    foreach (dflt[k]) begin
      {i, s, v} = dflt[k];
      if (k < 13 || k == 19 || k > 21) begin
        ax(1'b1, i, s, ~v, 32'h0, ERR_READ_ONLY);
        ax(1'b0, i, s, 32'h0, v, ERR_NONE);
      end
    end
  endtask : t_read_only

  task automatic t_modes;
    logic [15:0] c [5] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h22};
    foreach (c[k]) begin
      ax(1'b1, 16'h1c33, 8'h01, 32'(c[k]), 32'h0, ERR_NONE);
      chk(32'(sync_mode_o), 32'(c[k]));
      chk({31'h0, dc_active_o}, {31'h0, c[k] inside {16'h2, 16'h3}});
    end
    ax(1'b1, 16'h1c33, 8'h01, 32'h4, 32'h0, ERR_BAD_VALUE);
    ax(1'b1, 16'h1c33, 8'h01, 32'h10022, 32'h0, ERR_BAD_VALUE);
    chk(32'(sync_mode_o), 32'h22);
  endtask : t_modes

  task automatic t_writable;
    ax(1'b1, 16'h1c33, 8'h02, 32'hdeadbeef, 32'h0, ERR_NONE);
    chk(cycle_time_o, 32'hdeadbeef);
    ax(1'b0, 16'h1c33, 8'h02, 32'h0, 32'hdeadbeef, ERR_NONE);
    ax(1'b1, 16'h1c12, 8'h00, 32'h0, 32'h0, ERR_NONE);
    ax(1'b1, 16'h1c12, 8'h00, 32'h1, 32'h0, ERR_BAD_VALUE);
    ax(1'b0, 16'h1c12, 8'h00, 32'h0, 32'h0, ERR_NONE);
    ax(1'b1, 16'h1c13, 8'h69, 32'h0, 32'h0, ERR_NO_OBJECT);
    ax(1'b1, 16'h1c13, 8'h00, 32'h69, 32'h0, ERR_BAD_VALUE);
  endtask : t_writable

  // Walks: default list, samples, empty list, then all 104 slots
  task automatic t_walks;
    ts_words();
    exp_q.push_back({1'b1, cnt});
    walk();
    ax(1'b1, 16'h1c13, 8'h01, 32'h1a71, 32'h0, ERR_NONE);
    ax(1'b1, 16'h1c13, 8'h02, 32'h1a72, 32'h0, ERR_NONE);
    exp_q = '{{1'b1, s49}, {1'b1, s50}};
    walk();
    ax(1'b1, 16'h1c13, 8'h00, 32'h0, 32'h0, ERR_NONE);
    walk();
    ax(1'b1, 16'h1c13, 8'h03, 32'h1234, 32'h0, ERR_NONE);
    ax(1'b1, 16'h1c13, 8'h68, 32'h1a80, 32'h0, ERR_NONE);
    ax(1'b0, 16'h1c13, 8'h68, 32'h0, 32'h1a80, ERR_NONE);
    ax(1'b1, 16'h1c13, 8'h00, 32'h68, 32'h0, ERR_NONE);
    ts = 64'h0f0e_0d0c_0b0a_0908;
    exp_q = '{{1'b1, s49}, {1'b1, s50}};
    ts_words();
    walk();
  endtask : t_walks

  // A reset in mid-run must bring back the delivered configuration
  task automatic t_reset;
    @(negedge clk_i);
    sys_rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    sys_rst_i = 1'b0;
    chk(32'(sync_mode_o), 32'h22);
    chk(cycle_time_o, 32'h000f4240);
    ax(1'b0, 16'h1c13, 8'h00, 32'h0, 32'h2, ERR_NONE);
    ax(1'b0, 16'h1c13, 8'h01, 32'h0, 32'h1a80, ERR_NONE);
    ax(1'b0, 16'h1c13, 8'h68, 32'h0, 32'h0, ERR_NONE);
  endtask : t_reset

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_defaults();
    t_read_only();
    t_modes();
    t_writable();
    t_walks();
    t_reset();
    end_of_test();
  end
endmodule : tb
